// File: bench/test_trigger_level_dac_control.sv
`timescale 1ns/10ps
`include "tldac_defs.svh"

module test_trigger_level_dac_control;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic [7:0]  host_port;
  logic        str_a;
  logic        str_b;
  logic        str_m;
  logic        sel;
  logic [5:0]  misc;
  logic [7:0]  code_a;
  logic [7:0]  code_b;
  logic signed [12:0] mv_a;
  logic signed [12:0] mv_b;
  int          error_cnt = 0;
  int          n_compared = 0;
  logic [31:0] rd;
  logic [1:0]  rs;

  always #25 aclk = ~aclk;

  tldac_host_model host (.aclk(aclk), .host_port(host_port),
    .dac_a_load_strobe(str_a), .dac_b_load_strobe(str_b),
    .misc_latch_strobe(str_m));

  tldac_top dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .host_port(host_port),
    .dac_a_load_strobe(str_a), .dac_b_load_strobe(str_b),
    .misc_latch_strobe(str_m), .trigger_source_select(sel),
    .misc_ctrl(misc), .level_a_code(code_a), .level_b_code(code_b),
    .level_a_mv(mv_a), .level_b_mv(mv_b));

  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic timed_out;
    error_cnt++;
    $display("CHECK FAILED bus wait expected answer seen none");
    finish_test;
  endtask : timed_out

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    logic ta;
    logic tw;
    logic tb;
    int   n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r  = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) break;
    end
    if (n == 50) timed_out();
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ta;
    logic tr;
    int   n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) break;
    end
    if (n == 50) timed_out();
    rready <= 1'b0;
  endtask : axi_rd

  task automatic test_reset;
    chk("select", 32'(sel), 32'h1);
    chk("misc", 32'(misc), 32'h01);
    axi_rd(`TLDAC_OFS_STATUS, rd, rs);
    chk("status", rd, 32'h01);
    $display("test reset done");
  endtask : test_reset

  task automatic test_channel_a;
    host.send(0, 8'hFF);
    chk("code a", 32'(code_a), 32'hFF);
    chk("mv a neg", 32'(mv_a), -32'sd2550);
    chk("code b", 32'(code_b), 32'h00);
    host.send(2, 8'hC3);
    chk("misc", 32'(misc), 32'h03);
    chk("select", 32'(sel), 32'h1);
    chk("mv a pos", 32'(mv_a), 32'sd2550);
    $display("test channel a done");
  endtask : test_channel_a

  task automatic test_commands;
    axi_wr(`TLDAC_OFS_CMD, 32'h2, 4'hF, rs);
    chk("bresp", 32'(rs), 32'h0);
    chk("remote", 32'(sel), 32'h0);
    axi_wr(`TLDAC_OFS_CMD, 32'h4, 4'hF, rs);
    chk("local", 32'(sel), 32'h1);
    axi_wr(`TLDAC_OFS_CMD, 32'h2, 4'hF, rs);
    axi_wr(`TLDAC_OFS_CMD, 32'h6, 4'hF, rs);
    chk("local wins", 32'(sel), 32'h1);
    axi_wr(`TLDAC_OFS_CMD, 32'h2, 4'hF, rs);
    axi_wr(`TLDAC_OFS_CMD, 32'h1, 4'hF, rs);
    repeat (2) @(posedge aclk);
    chk("init select", 32'(sel), 32'h1);
    chk("init misc", 32'(misc), 32'h01);
    chk("init mv a", 32'(mv_a), -32'sd2550);
    $display("test commands done");
  endtask : test_commands

  task automatic test_channel_b;
    host.send(1, 8'h80);
    chk("code b", 32'(code_b), 32'h80);
    chk("mv b", 32'(mv_b), -32'sd1280);
    chk("code a kept", 32'(code_a), 32'hFF);
    host.traffic(8'h11);
    chk("a after traffic", 32'(code_a), 32'hFF);
    chk("b after traffic", 32'(code_b), 32'h80);
    axi_rd(`TLDAC_OFS_LEVEL_A, rd, rs);
    chk("level a reg", rd, 32'hF60A00FF);
    axi_rd(`TLDAC_OFS_LEVEL_B, rd, rs);
    chk("level b reg", rd, 32'hFB000080);
    host.send(2, 8'h3D);
    chk("misc pol b", 32'(misc), 32'h3D);
    chk("mv b pos", 32'(mv_b), 32'sd1280);
    chk("mv a kept", 32'(mv_a), -32'sd2550);
    axi_rd(`TLDAC_OFS_LEVEL_B, rd, rs);
    chk("level b pos reg", rd, 32'h05000180);
    host.send(2, 8'h01);
    chk("mv b toggled", 32'(mv_b), -32'sd1280);
    chk("misc toggled", 32'(misc), 32'h01);
    $display("test channel b done");
  endtask : test_channel_b

  task automatic test_bus_errors;
    axi_rd(8'h10, rd, rs);
    chk("unmapped resp", 32'(rs), 32'h2);
    chk("unmapped data", rd, 32'h0);
    axi_wr(`TLDAC_OFS_STATUS, 32'h0, 4'hF, rs);
    chk("ro resp", 32'(rs), 32'h2);
    axi_wr(`TLDAC_OFS_CMD, 32'h2, 4'h0, rs);
    chk("no strobe", 32'(sel), 32'h1);
    axi_rd(`TLDAC_OFS_STATUS, rd, rs);
    chk("status kept", rd, 32'h01);
    $display("test bus errors done");
  endtask : test_bus_errors

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    test_reset();
    test_channel_a();
    test_commands();
    test_channel_b();
    test_bus_errors();
    finish_test();
  end
endmodule : test_trigger_level_dac_control

// File: bench/tldac_host_model.sv
`timescale 1ns/10ps
`include "tldac_defs.svh"

module tldac_host_model (
  input  wire logic                     aclk,
  output logic [`TLDAC_CODE_W-1:0]      host_port,
  output logic                          dac_a_load_strobe,
  output logic                          dac_b_load_strobe,
  output logic                          misc_latch_strobe
);
  logic [`TLDAC_CODE_W-1:0] saved;

  initial begin
    host_port         = 8'h5A;
    dac_a_load_strobe = 1'b0;
    dac_b_load_strobe = 1'b0;
    misc_latch_strobe = 1'b0;
  end

  // sel 0 = channel a, 1 = channel b, 2 = misc latch
  task automatic strobe(input int sel, input logic lvl);
    case (sel)
      0: dac_a_load_strobe <= lvl;
      1: dac_b_load_strobe <= lvl;
      default: misc_latch_strobe <= lvl; // polarity bits
    endcase
  endtask : strobe

  task automatic send(input int sel, input logic [7:0] value);
    @(posedge aclk);
    saved = host_port;
    host_port <= value;
    repeat (2) @(posedge aclk);
    strobe(sel, 1'b1);
    repeat (3) @(posedge aclk);
    strobe(sel, 1'b0);
    repeat (2) @(posedge aclk);
    host_port <= saved;
    @(posedge aclk);
  endtask : send

  // port traffic meant for other circuits, no strobe
  task automatic traffic(input logic [7:0] value);
    @(posedge aclk);
    host_port <= value;
    repeat (4) @(posedge aclk);
  endtask : traffic
endmodule : tldac_host_model

// File: core/tldac_channel.sv
`timescale 1ns/10ps
`include "tldac_defs.svh"

module tldac_channel (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  tldac_port_if.snk              port,
  input  tldac_pkg::tldac_pol_e  pol,
  output tldac_pkg::tldac_code_t code_q,
  output tldac_pkg::tldac_level_t level_q
);

  localparam int LW = `TLDAC_LEVEL_W;

  logic [LW-1:0]          mag;
  tldac_pkg::tldac_level_t level_d;

  // magnitude in mV and sign from polarity
  assign mag     = LW'(code_q) * LW'(`TLDAC_STEP_MV);
  assign level_d = (pol == tldac_pkg::TLDAC_POS) ? $signed(mag)
                                                 : -$signed(mag);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_q  <= '0;
      level_q <= '0;
    end else begin
      if (port.load) begin
        code_q <= port.data;
      end
      level_q <= level_d;
    end
  end

  property p_load_capture;
    @(posedge aclk) disable iff (!aresetn)
      port.load |=> (code_q == $past(port.data));
  endproperty
  a_load_capture: assert property (p_load_capture)
    else $error("code not captured on load strobe");

  property p_code_hold;
    @(posedge aclk) disable iff (!aresetn)
      !port.load |=> $stable(code_q);
  endproperty
  a_code_hold: assert property (p_code_hold)
    else $error("code changed without its own strobe");

  property p_neg_span;
    @(posedge aclk) disable iff (!aresetn)
      (pol == tldac_pkg::TLDAC_NEG) |=>
        (int'(level_q) == -10 * int'($past(code_q)));
  endproperty
  a_neg_span: assert property (p_neg_span)
    else $error("negative level not minus ten mV per code");

  property p_pos_span;
    @(posedge aclk) disable iff (!aresetn)
      (pol == tldac_pkg::TLDAC_POS) |=>
        (int'(level_q) == 10 * int'($past(code_q)));
  endproperty
  a_pos_span: assert property (p_pos_span)
    else $error("positive level not ten mV per code");

endmodule : tldac_channel

// File: core/tldac_defs.svh
// Overview of operation
// - each channel latches the 8-bit host port on its load strobe rising edge
// - two identical channels A and B, own latch and strobe, shared port
// - 6-bit misc latch captures host port on the misc latch strobe
// - trigger source select is high after reset and after an initialize written without remote
// - remote level command drives the trigger source select low unless local is in the same write
// - local level command drives the trigger source select high
// - 10 mV per code step; negative polarity spans 0 down to -2.55 V
// - positive polarity spans 0 up to +2.55 V in 10 mV steps
`ifndef TLDAC_DEFS_SVH
`define TLDAC_DEFS_SVH

`define TLDAC_CODE_W      8
`define TLDAC_MISC_W      6
`define TLDAC_STEP_MV     10
`define TLDAC_LEVEL_W     13
`define TLDAC_ADDR_W      8

`define TLDAC_OFS_CMD     8'h00
`define TLDAC_OFS_STATUS  8'h04
`define TLDAC_OFS_LEVEL_A 8'h08
`define TLDAC_OFS_LEVEL_B 8'h0C

`define TLDAC_MISC_RST    6'h01
`define TLDAC_SEL_BIT     0
`define TLDAC_POL_A_BIT   1
`define TLDAC_POL_B_BIT   2

`define TLDAC_CMD_INIT    0
`define TLDAC_CMD_REMOTE  1
`define TLDAC_CMD_LOCAL   2

`define TLDAC_RESP_OKAY   2'h0
`define TLDAC_RESP_SLVERR 2'h2

`endif

// File: core/tldac_pkg.sv
`include "tldac_defs.svh"

package tldac_pkg;

  typedef logic [`TLDAC_CODE_W-1:0]         tldac_code_t;
  typedef logic [`TLDAC_MISC_W-1:0]         tldac_misc_t;
  typedef logic signed [`TLDAC_LEVEL_W-1:0] tldac_level_t;

  typedef enum logic {
    TLDAC_NEG = 1'b0,
    TLDAC_POS = 1'b1
  } tldac_pol_e;

endpackage : tldac_pkg

// File: core/tldac_port_if.sv
`timescale 1ns/10ps
`include "tldac_defs.svh"

interface tldac_port_if;
  logic [`TLDAC_CODE_W-1:0] data;
  logic                     load;

  modport src (output data, output load);
  modport snk (input data, input load);
endinterface : tldac_port_if

// File: core/tldac_sync.sv
`timescale 1ns/10ps

module tldac_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : tldac_sync

// File: core/tldac_top.sv
`timescale 1ns/10ps
`include "tldac_defs.svh"

module tldac_top (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [`TLDAC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]               s_axi_awprot,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`TLDAC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]               s_axi_arprot,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [`TLDAC_CODE_W-1:0] host_port,
  input  wire logic                     dac_a_load_strobe,
  input  wire logic                     dac_b_load_strobe,
  input  wire logic                     misc_latch_strobe,
  output logic                          trigger_source_select,
  output tldac_pkg::tldac_misc_t        misc_ctrl,
  output tldac_pkg::tldac_code_t        level_a_code,
  output tldac_pkg::tldac_code_t        level_b_code,
  output tldac_pkg::tldac_level_t       level_a_mv,
  output tldac_pkg::tldac_level_t       level_b_mv
);

  localparam int CW = `TLDAC_CODE_W;
  localparam int SW = CW + 3;
  localparam int AW = `TLDAC_ADDR_W;

  function automatic logic word_is(input logic [AW-3:0] word,
                                   input logic [AW-1:0] ofs);
    return word == ofs[AW-1:2];
  endfunction : word_is

  // pin synchronisation and strobe edges

  logic [SW-1:0]          pins_s;
  logic [CW-1:0]          port_s;
  logic                   str_a_s;
  logic                   str_b_s;
  logic                   str_m_s;
  logic                   str_a_q;
  logic                   str_b_q;
  logic                   str_m_q;
  logic                   load_a;
  logic                   load_b;
  logic                   misc_load;

  tldac_sync #(
    .W (SW)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({misc_latch_strobe, dac_b_load_strobe, dac_a_load_strobe,
               host_port}),
    .q       (pins_s)
  );

  // data and strobes share one delay so the code stays aligned
  assign port_s    = pins_s[CW-1:0];
  assign str_a_s   = pins_s[CW];
  assign str_b_s   = pins_s[CW+1];
  assign str_m_s   = pins_s[CW+2];
  assign load_a    = str_a_s & ~str_a_q;
  assign load_b    = str_b_s & ~str_b_q;
  assign misc_load = str_m_s & ~str_m_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      str_a_q <= 1'b0;
      str_b_q <= 1'b0;
      str_m_q <= 1'b0;
    end else begin
      str_a_q <= str_a_s;
      str_b_q <= str_b_s;
      str_m_q <= str_m_s;
    end
  end

  // axi4-lite write path

  logic                   aw_hold_q;
  logic [AW-1:0]          awaddr_q;
  logic                   w_hold_q;
  logic [31:0]            wdata_q;
  logic [3:0]             wstrb_q;
  logic                   aw_have;
  logic                   w_have;
  logic [AW-1:0]          wr_addr;
  logic [31:0]            wr_data;
  logic [3:0]             wr_strb;
  logic                   wr_fire;
  logic                   wr_cmd;
  logic [1:0]             wr_resp;

  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
  assign aw_have = aw_hold_q | (s_axi_awvalid & s_axi_awready);
  assign w_have  = w_hold_q | (s_axi_wvalid & s_axi_wready);
  assign wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_hold_q ? wdata_q : s_axi_wdata;
  assign wr_strb = w_hold_q ? wstrb_q : s_axi_wstrb;
  assign wr_fire = aw_have & w_have & ~s_axi_bvalid;
  assign wr_cmd  = word_is(wr_addr[AW-1:2], `TLDAC_OFS_CMD);
  assign wr_resp = wr_cmd ? `TLDAC_RESP_OKAY : `TLDAC_RESP_SLVERR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q    <= 1'b0;
      awaddr_q     <= '0;
      w_hold_q     <= 1'b0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TLDAC_RESP_OKAY;
    end else begin
      aw_hold_q <= aw_have & ~wr_fire;
      w_hold_q  <= w_have & ~wr_fire;
      awaddr_q  <= wr_addr;
      wdata_q   <= wr_data;
      wstrb_q   <= wr_strb;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_resp;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // command pulses from a write to the command register

  logic                   cmd_en;
  logic                   cmd_init;
  logic                   cmd_remote;
  logic                   cmd_local;

  assign cmd_en     = wr_fire & wr_cmd & wr_strb[0];
  assign cmd_init   = cmd_en & wr_data[`TLDAC_CMD_INIT];
  assign cmd_remote = cmd_en & wr_data[`TLDAC_CMD_REMOTE];
  assign cmd_local  = cmd_en & wr_data[`TLDAC_CMD_LOCAL];

  // miscellaneous latch and trigger source select

  tldac_pkg::tldac_misc_t misc_q;
  tldac_pkg::tldac_misc_t misc_cap;
  tldac_pkg::tldac_misc_t misc_ini;
  tldac_pkg::tldac_misc_t misc_d;
  logic                   sel_d;

  assign misc_cap = misc_load ? port_s[`TLDAC_MISC_W-1:0] : misc_q;
  assign misc_ini = cmd_init ? `TLDAC_MISC_RST : misc_cap;
  // local wins when both commands arrive together
  assign sel_d = cmd_local  ? 1'b1 :
                 cmd_remote ? 1'b0 :
                 misc_ini[`TLDAC_SEL_BIT];
  assign misc_d = {misc_ini[`TLDAC_MISC_W-1:1], sel_d};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      misc_q <= `TLDAC_MISC_RST;
    end else begin
      misc_q <= misc_d;
    end
  end

  assign misc_ctrl             = misc_q;
  assign trigger_source_select = misc_q[`TLDAC_SEL_BIT];

  // two identical converter channels on the shared port

  tldac_port_if port_a ();
  tldac_port_if port_b ();

  assign port_a.data = port_s;
  assign port_a.load = load_a;
  assign port_b.data = port_s;
  assign port_b.load = load_b;

  tldac_channel u_chan_a (
    .aclk    (aclk),
    .aresetn (aresetn),
    .port    (port_a),
    .pol     (tldac_pkg::tldac_pol_e'(misc_q[`TLDAC_POL_A_BIT])),
    .code_q  (level_a_code),
    .level_q (level_a_mv)
  );

  tldac_channel u_chan_b (
    .aclk    (aclk),
    .aresetn (aresetn),
    .port    (port_b),
    .pol     (tldac_pkg::tldac_pol_e'(misc_q[`TLDAC_POL_B_BIT])),
    .code_q  (level_b_code),
    .level_q (level_b_mv)
  );

  // axi4-lite read path

  logic [AW-3:0]          rd_word;
  logic                   rd_hit;
  logic [31:0]            rd_mux;
  logic [31:0]            rd_lvl_a;
  logic [31:0]            rd_lvl_b;

  assign rd_word  = s_axi_araddr[AW-1:2];
  assign rd_lvl_a = {{3{level_a_mv[`TLDAC_LEVEL_W-1]}}, level_a_mv, 7'h00,
                     misc_q[`TLDAC_POL_A_BIT], level_a_code};
  assign rd_lvl_b = {{3{level_b_mv[`TLDAC_LEVEL_W-1]}}, level_b_mv, 7'h00,
                     misc_q[`TLDAC_POL_B_BIT], level_b_code};
  assign rd_hit   = word_is(rd_word, `TLDAC_OFS_CMD) |
                    word_is(rd_word, `TLDAC_OFS_STATUS) |
                    word_is(rd_word, `TLDAC_OFS_LEVEL_A) |
                    word_is(rd_word, `TLDAC_OFS_LEVEL_B);
  assign rd_mux   = word_is(rd_word, `TLDAC_OFS_STATUS)  ? 32'(misc_q) :
                    word_is(rd_word, `TLDAC_OFS_LEVEL_A) ? rd_lvl_a :
                    word_is(rd_word, `TLDAC_OFS_LEVEL_B) ? rd_lvl_b :
                    32'h0000_0000;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `TLDAC_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? `TLDAC_RESP_OKAY : `TLDAC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks

  property p_misc_capture;
    @(posedge aclk) disable iff (!aresetn)
      (misc_load & ~cmd_en) |=>
        (misc_ctrl == $past(port_s[`TLDAC_MISC_W-1:0]));
  endproperty
  a_misc_capture: assert property (p_misc_capture)
    else $error("misc latch missed its strobe");

  property p_reset_high;
    @(posedge aclk) disable iff (!aresetn)
      $past(!aresetn) |-> (trigger_source_select && !s_axi_bvalid);
  endproperty
  a_reset_high: assert property (p_reset_high)
    else $error("select not high after reset");

  property p_init_high;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_init & ~cmd_remote) |=> trigger_source_select ##0
        (misc_ctrl == `TLDAC_MISC_RST);
  endproperty
  a_init_high: assert property (p_init_high)
    else $error("initialize did not restore select high");

  property p_remote_low;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_remote & ~cmd_local) |=> !trigger_source_select;
  endproperty
  a_remote_low: assert property (p_remote_low)
    else $error("remote command did not drive select low");

  property p_local_high;
    @(posedge aclk) disable iff (!aresetn)
      cmd_local |=> trigger_source_select;
  endproperty
  a_local_high: assert property (p_local_high)
    else $error("local command did not drive select high");

  property p_chan_indep;
    @(posedge aclk) disable iff (!aresetn)
      (load_a & ~load_b) |=> $stable(level_b_code) ##0
        (level_a_code == $past(port_s));
  endproperty
  a_chan_indep: assert property (p_chan_indep)
    else $error("channel strobe disturbed the other channel");

  property p_strobe_edge;
    @(posedge aclk) disable iff (!aresetn)
      $rose(str_a_s) |-> load_a ##1 !load_a;
  endproperty
  a_strobe_edge: assert property (p_strobe_edge)
    else $error("load pulse not one cycle on strobe edge");

  property p_write_resp;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid ##0 (s_axi_bresp == $past(wr_resp));
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write response missing or wrong");

  property p_read_resp;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid & s_axi_arready) |=> s_axi_rvalid ##0
        (s_axi_rdata == $past(rd_mux));
  endproperty
  a_read_resp: assert property (p_read_resp)
    else $error("read data missing or wrong");

endmodule : tldac_top
